// File: hw/board_io_pkg.sv
/*
 * Shared constants and types for the board user I/O front end.
 * Assumes a single 125 MHz ref_clk domain shared by both ends.
 */
package board_io_pkg;
    localparam int  CLK_HZ            = 125_000_000;
    localparam int  NUM_SWITCHES      = 8;
    localparam int  NUM_BUTTONS       = 4;
    localparam int  NUM_LEDS          = 8;
    localparam int  NUM_SEGMENTS      = 7;
    localparam int  NUM_GENERAL       = 32;
    localparam int  NUM_RANGES        = 3;
    // Switch bounce interval, microseconds
    localparam int  BOUNCE_US         = 2000;
    localparam int  BOUNCE_CYCLES     = (CLK_HZ / 1_000_000) * BOUNCE_US;
    // Display refresh slot per digit, microseconds
    localparam int  REFRESH_US        = 1000;
    localparam int  REFRESH_CYCLES    = (CLK_HZ / 1_000_000) * REFRESH_US;
    // Knob clock range limits, Hz
    localparam int  LOW_MIN_HZ        = 1;
    localparam int  LOW_MAX_HZ        = 100;
    localparam int  MID_MAX_HZ        = 100_000;
    localparam int  HIGH_MAX_HZ       = 5_000_000;
    localparam int  STEP_W            = 16;
    localparam logic       DIGIT_ON   = 1'b0;
    localparam logic       DIGIT_OFF  = 1'b1;
    typedef enum logic [1:0] {RANGE_LOW, RANGE_MID, RANGE_HIGH} range_t;
    typedef enum logic {SHOW_DIGIT0, SHOW_DIGIT1} digit_sel_t;
endpackage : board_io_pkg

// File: hw/board_io_if.sv
/*
 * Pin-level link between the board model end and the user logic end.
 * General lines are two signals per end; the wire level is resolved here.
 */
`timescale 1ns/1ps
interface board_io_if;
    import board_io_pkg::*;
    logic [NUM_SWITCHES-1:0] slide_switch_input;
    logic [NUM_BUTTONS-1:0]  push_button_input;
    logic [NUM_LEDS-1:0]     discrete_led_output;
    logic [NUM_SEGMENTS-1:0] digit0_segment_line;
    logic [NUM_SEGMENTS-1:0] digit1_segment_line;
    logic                    digit0_enable_n;
    logic                    digit1_enable_n;
    logic [NUM_GENERAL-1:0]  line_from_user;
    logic [NUM_GENERAL-1:0]  line_oe_n_user;
    logic [NUM_GENERAL-1:0]  line_from_board;
    logic [NUM_GENERAL-1:0]  line_oe_n_board;
    logic [NUM_GENERAL-1:0]  general_line;
    // Wire level: user drive wins, then board drive, else pulled low
    genvar g;
    for (g = 0; g < NUM_GENERAL; g++) begin : g_res
        assign general_line[g] = !line_oe_n_user[g]  ? line_from_user[g]  :
                                 !line_oe_n_board[g] ? line_from_board[g] : 1'b0;
    end
    modport board (output slide_switch_input, push_button_input,
                   input discrete_led_output, digit0_segment_line, digit1_segment_line,
                   input digit0_enable_n, digit1_enable_n,
                   output line_from_board, line_oe_n_board, input general_line);
    modport user  (input slide_switch_input, push_button_input,
                   output discrete_led_output, digit0_segment_line, digit1_segment_line,
                   output digit0_enable_n, digit1_enable_n,
                   output line_from_user, line_oe_n_user, input general_line);
endinterface : board_io_if

// File: hw/board_end.sv
/*
 * Board end: presents switch and button levels, shows LED and display
 * state, mirrors general lines, and runs the knob clock generator.
 * Assumes synchronous raw contact levels from the user-side port list.
 */
// Functional notes
// - Switch up reads high, down low
// - Switch lines bounce about 2 ms
// - Pressed button reads high
// - Buttons arrive already RC filtered
// - LED lights when its line is high
// - Segment lights when its line is high
// - Digit enables allow multiplexing two digits
// - Digit enable lines are active low
// - Each general line has own direction
// - Knob press steps to next range
// - Low range spans 1 to 100 Hz
// - Middle range spans 100 Hz to 100 kHz
// - High range spans 100 kHz to 5 MHz
// - Knob clock never reaches user logic
// - Oscillator clocks all user logic
`timescale 1ns/1ps
module board_end
    import board_io_pkg::*;
(
    input  wire logic                            ref_clk,
    input  wire logic                            nrst,
    board_io_if.board                            pins,
    input  wire logic [board_io_pkg::NUM_SWITCHES-1:0] switch_up,
    input  wire logic [board_io_pkg::NUM_BUTTONS-1:0]  button_pressed,
    input  wire logic                            knob_press,
    input  wire logic [board_io_pkg::STEP_W-1:0] knob_setting,
    input  wire logic [board_io_pkg::NUM_GENERAL-1:0]  ext_drive,
    input  wire logic [board_io_pkg::NUM_GENERAL-1:0]  ext_oe_n,
    output logic      [board_io_pkg::NUM_LEDS-1:0]     led_lit,
    output logic      [board_io_pkg::NUM_SEGMENTS-1:0] digit0_lit,
    output logic      [board_io_pkg::NUM_SEGMENTS-1:0] digit1_lit,
    output logic      [board_io_pkg::NUM_GENERAL-1:0]  ext_level,
    output logic                                 low_range_indicator,
    output logic                                 mid_range_indicator,
    output logic                                 high_range_indicator,
    output logic                                 knob_clock_output
);
    import board_io_pkg::*;

    range_t            range_q,    range_d;
    logic              press_q,    press_d;
    logic [31:0]       half_q,     half_d;
    logic [31:0]       cnt_q,      cnt_d;
    logic              kclk_q,     kclk_d;
    logic [NUM_SWITCHES-1:0] sw_q;
    logic [NUM_BUTTONS-1:0]  bt_q;

    // Contact levels straight onto the user lines
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            sw_q <= '0;
            bt_q <= '0;
        end else begin
            sw_q <= switch_up;      // raw, bounces pass through
            bt_q <= button_pressed; // already filtered upstream
        end
    end
    assign pins.slide_switch_input = sw_q;
    assign pins.push_button_input  = bt_q;
    assign pins.line_from_board    = ext_drive;
    assign pins.line_oe_n_board    = ext_oe_n;

    // Target frequency within range from knob position
    function automatic logic [31:0] target_hz(range_t r, logic [STEP_W-1:0] k);
        logic [31:0] lo;
        logic [31:0] hi;
        lo = 32'(LOW_MIN_HZ);
        hi = 32'(LOW_MAX_HZ);
        unique case (r)
            RANGE_LOW:  begin lo = 32'(LOW_MIN_HZ); hi = 32'(LOW_MAX_HZ);  end
            RANGE_MID:  begin lo = 32'(LOW_MAX_HZ); hi = 32'(MID_MAX_HZ);  end
            RANGE_HIGH: begin lo = 32'(MID_MAX_HZ); hi = 32'(HIGH_MAX_HZ); end
        endcase
        target_hz = lo + 32'((64'(hi - lo) * 64'(k)) >> STEP_W);
    endfunction : target_hz

    // Range stepping and knob clock divider
    always_comb begin
        press_d = knob_press;
        range_d = range_q;
        if (knob_press && !press_q) begin
            unique case (range_q)
                RANGE_LOW:  range_d = RANGE_MID;
                RANGE_MID:  range_d = RANGE_HIGH;
                RANGE_HIGH: range_d = RANGE_LOW;
                default:    range_d = RANGE_LOW;
            endcase
        end
        half_d = 32'(CLK_HZ / 2) / target_hz(range_q, knob_setting);
        if (half_d == '0) begin
            half_d = 32'd1;
        end
        cnt_d  = cnt_q + 32'd1;
        kclk_d = kclk_q;
        if (cnt_q + 32'd1 >= half_q) begin
            cnt_d  = '0;
            kclk_d = !kclk_q;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            range_q <= RANGE_LOW;
            press_q <= 1'b0;
            half_q  <= 32'd1;
            cnt_q   <= '0;
            kclk_q  <= 1'b0;
        end else begin
            range_q <= range_d;
            press_q <= press_d;
            half_q  <= half_d;
            cnt_q   <= cnt_d;
            kclk_q  <= kclk_d;
        end
    end

    // Observed state of lamps, display, lines; knob clock stays local
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            led_lit              <= '0;
            digit0_lit           <= '0;
            digit1_lit           <= '0;
            ext_level            <= '0;
            low_range_indicator  <= 1'b0;
            mid_range_indicator  <= 1'b0;
            high_range_indicator <= 1'b0;
            knob_clock_output    <= 1'b0;
        end else begin
            led_lit    <= pins.discrete_led_output;
            digit0_lit <= (pins.digit0_enable_n == DIGIT_ON) ?
                          pins.digit0_segment_line : '0;
            digit1_lit <= (pins.digit1_enable_n == DIGIT_ON) ?
                          pins.digit1_segment_line : '0;
            ext_level  <= pins.general_line;
            low_range_indicator  <= (range_q == RANGE_LOW);
            mid_range_indicator  <= (range_q == RANGE_MID);
            high_range_indicator <= (range_q == RANGE_HIGH);
            knob_clock_output    <= kclk_q; // breadboard only
        end
    end
endmodule : board_end

// File: hw/user_end.sv
/*
 * User logic end: debounces switches, drives LEDs, multiplexes the
 * two-digit display, and drives general lines with per-line direction.
 * Assumes ref_clk stands in for the board oscillator clock.
 */
`timescale 1ns/1ps
module user_end
    import board_io_pkg::*;
#(
    parameter int BOUNCE_LEN  = board_io_pkg::BOUNCE_CYCLES,
    parameter int REFRESH_LEN = board_io_pkg::REFRESH_CYCLES
) (
    input  wire logic                            ref_clk,
    input  wire logic                            nrst,
    board_io_if.user                             pins,
    input  wire logic [board_io_pkg::NUM_LEDS-1:0]     led_on,
    input  wire logic [board_io_pkg::NUM_SEGMENTS-1:0] pattern0,
    input  wire logic [board_io_pkg::NUM_SEGMENTS-1:0] pattern1,
    input  wire logic [board_io_pkg::NUM_GENERAL-1:0]  line_out,
    input  wire logic [board_io_pkg::NUM_GENERAL-1:0]  line_is_output,
    output logic      [board_io_pkg::NUM_SWITCHES-1:0] switch_state,
    output logic      [board_io_pkg::NUM_BUTTONS-1:0]  button_state,
    output logic      [board_io_pkg::NUM_GENERAL-1:0]  line_in
);
    import board_io_pkg::*;

    logic [31:0]       db_cnt_q [NUM_SWITCHES];
    logic [31:0]       db_cnt_d [NUM_SWITCHES];
    logic [NUM_SWITCHES-1:0] stable_q, stable_d;
    digit_sel_t        sel_q, sel_d;
    logic [31:0]       ref_q, ref_d;

    // Per-switch debounce: accept level after held BOUNCE_LEN cycles
    genvar i;
    for (i = 0; i < NUM_SWITCHES; i++) begin : g_db
        always_comb begin
            db_cnt_d[i] = '0;
            stable_d[i] = stable_q[i];
            if (pins.slide_switch_input[i] != stable_q[i]) begin
                db_cnt_d[i] = db_cnt_q[i] + 32'd1;
                if (db_cnt_q[i] + 32'd1 >= 32'(BOUNCE_LEN)) begin
                    stable_d[i] = pins.slide_switch_input[i];
                    db_cnt_d[i] = '0;
                end
            end
        end
        always_ff @(posedge ref_clk) begin
            if (!nrst) begin
                db_cnt_q[i] <= '0;
                stable_q[i] <= 1'b0;
            end else begin
                db_cnt_q[i] <= db_cnt_d[i];
                stable_q[i] <= stable_d[i];
            end
        end
    end

    // Display refresh slot timer
    always_comb begin
        ref_d = ref_q + 32'd1;
        sel_d = sel_q;
        if (ref_q + 32'd1 >= 32'(REFRESH_LEN)) begin
            ref_d = '0;
            sel_d = (sel_q == SHOW_DIGIT0) ? SHOW_DIGIT1 : SHOW_DIGIT0;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            ref_q <= '0;
            sel_q <= SHOW_DIGIT0;
        end else begin
            ref_q <= ref_d;
            sel_q <= sel_d;
        end
    end

    // Pin drivers, all registered
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            pins.discrete_led_output <= '0;
            pins.digit0_segment_line <= '0;
            pins.digit1_segment_line <= '0;
            pins.digit0_enable_n     <= DIGIT_OFF;
            pins.digit1_enable_n     <= DIGIT_OFF;
            pins.line_from_user      <= '0;
            pins.line_oe_n_user      <= '1;
            switch_state             <= '0;
            button_state             <= '0;
            line_in                  <= '0;
        end else begin
            pins.discrete_led_output <= led_on;
            pins.digit0_segment_line <= pattern0;
            pins.digit1_segment_line <= pattern1;
            // Exactly one digit enabled, active low
            pins.digit0_enable_n <= (sel_q == SHOW_DIGIT0) ? DIGIT_ON : DIGIT_OFF;
            pins.digit1_enable_n <= (sel_q == SHOW_DIGIT1) ? DIGIT_ON : DIGIT_OFF;
            pins.line_from_user  <= line_out;
            pins.line_oe_n_user  <= ~line_is_output;
            switch_state         <= stable_q;
            button_state         <= pins.push_button_input;
            line_in              <= pins.general_line;
        end
    end
endmodule : user_end

// File: verif/board_io_assertions.sv
/* Wire-level checks on the link between board end and user end.
   Assumes one ref_clk domain and nrst synchronous, active low. */
`timescale 1ns/1ps
module board_io_assertions
    import board_io_pkg::*;
(
    input wire logic                                   ref_clk,
    input wire logic                                   nrst,
    input wire logic                                   digit0_enable_n,
    input wire logic                                   digit1_enable_n,
    input wire logic [board_io_pkg::NUM_GENERAL-1:0]   line_from_user,
    input wire logic [board_io_pkg::NUM_GENERAL-1:0]   line_oe_n_user,
    input wire logic [board_io_pkg::NUM_GENERAL-1:0]   line_from_board,
    input wire logic [board_io_pkg::NUM_GENERAL-1:0]   line_oe_n_board,
    input wire logic [board_io_pkg::NUM_GENERAL-1:0]   general_line
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // An enabled digit keeps its slot for a run of cycles
    sequence s_on0; (digit0_enable_n == DIGIT_ON) [*8]; endsequence
    sequence s_on1; (digit1_enable_n == DIGIT_ON) [*8]; endsequence
    property p_one_digit;
        !(digit0_enable_n == DIGIT_ON && digit1_enable_n == DIGIT_ON);
    endproperty
    property p_slot0; $fell(digit0_enable_n) |-> s_on0; endproperty
    property p_slot1; $fell(digit1_enable_n) |-> s_on1; endproperty
    property p_return0; $rose(digit0_enable_n) |-> ##[1:40] digit0_enable_n == DIGIT_ON; endproperty
    property p_swap; $rose(digit0_enable_n) |-> $fell(digit1_enable_n); endproperty
    // Wire level follows whichever end drives it
    property p_gen_user; ((general_line ^ line_from_user) & ~line_oe_n_user) == '0; endproperty
    property p_gen_board;
        ((general_line ^ line_from_board) & line_oe_n_user & ~line_oe_n_board) == '0;
    endproperty
    property p_oe_release; $rose(nrst) |-> &line_oe_n_user; endproperty
    a_one_digit: assert property (p_one_digit) else $error("both digits on");
    a_slot0: assert property (p_slot0) else $error("digit0 slot short");
    a_slot1: assert property (p_slot1) else $error("digit1 slot short");
    a_return0: assert property (p_return0) else $error("digit0 not refreshed");
    a_swap: assert property (p_swap) else $error("digit handover broken");
    a_gen_user: assert property (p_gen_user) else $error("user drive lost");
    a_gen_board: assert property (p_gen_board) else $error("board drive lost");
    a_oe_release: assert property (p_oe_release) else $error("line driven at reset");
endmodule : board_io_assertions

// File: verif/testbench.sv
/* Self-checking bench joining board end and user end through the link.
   Assumes short debounce and refresh counts set at the user end. */
`timescale 1ns/1ps
module testbench;
    import board_io_pkg::*;
    typedef struct {int due; int sel; logic [31:0] exp;} note_t;
    logic        ref_clk, nrst, knob_press;
    logic [7:0]  switch_up, led_on, led_lit, switch_state;
    logic [3:0]  button_pressed, button_state;
    logic [6:0]  pattern0, pattern1, digit0_lit, digit1_lit;
    logic        knob_clk, knob_last;
    int          knob_edges;
    logic [15:0] knob_setting;
    logic [31:0] ext_drive, ext_oe_n, ext_level, line_out, line_is_output, line_in;
    logic [31:0] a, b, c, d, e;
    logic        lo_ind, mid_ind, hi_ind;
    note_t       notes[$];
    int          mismatches, compares, cyc, seed, i;
    string       lbl[8] = '{"switch", "button", "led", "line_in", "ext_level", "range",
                            "knob_clk", "digit"};
    board_io_if pins_if();
    board_end i_board_end (.ref_clk(ref_clk), .nrst(nrst), .pins(pins_if),
        .switch_up(switch_up), .button_pressed(button_pressed), .knob_press(knob_press),
        .knob_setting(knob_setting), .ext_drive(ext_drive), .ext_oe_n(ext_oe_n),
        .led_lit(led_lit), .digit0_lit(digit0_lit), .digit1_lit(digit1_lit),
        .ext_level(ext_level),
        .low_range_indicator(lo_ind), .mid_range_indicator(mid_ind),
        .high_range_indicator(hi_ind), .knob_clock_output(knob_clk));
    user_end #(.BOUNCE_LEN(8), .REFRESH_LEN(16)) i_user_end (.ref_clk(ref_clk),
        .nrst(nrst), .pins(pins_if), .led_on(led_on), .pattern0(pattern0),
        .pattern1(pattern1), .line_out(line_out), .line_is_output(line_is_output),
        .switch_state(switch_state), .button_state(button_state), .line_in(line_in));
    board_io_assertions u_chk (.ref_clk(ref_clk), .nrst(nrst),
        .digit0_enable_n(pins_if.digit0_enable_n), .digit1_enable_n(pins_if.digit1_enable_n),
        .line_from_user(pins_if.line_from_user), .line_oe_n_user(pins_if.line_oe_n_user),
        .line_from_board(pins_if.line_from_board),
        .line_oe_n_board(pins_if.line_oe_n_board), .general_line(pins_if.general_line));
    // Clock, 8 ns period
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) cyc <= cyc + 1;
    // Output picked by selector code
    function automatic logic [31:0] seen(input int sel);
        case (sel)
            0: return {24'h0, switch_state};
            1: return {28'h0, button_state};
            2: return {24'h0, led_lit};
            3: return line_in;
            4: return ext_level;
            6: return 32'(knob_edges);
            // One digit shows its own pattern, the other stays dark
            7: return {31'h0, ((digit0_lit == pattern0) && (digit1_lit == 7'h00)) ||
                              ((digit1_lit == pattern1) && (digit0_lit == 7'h00))};
            default: return {29'h0, lo_ind, mid_ind, hi_ind};
        endcase
    endfunction : seen
    task automatic note(input int lat, input int sel, input logic [31:0] exp);
        notes.push_back('{cyc + lat, sel, exp});
    endtask : note
    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : tally_and_finish
    // Compare each due note with what the output shows
    always @(negedge ref_clk) begin : mon
        note_t n;
        while (notes.size() > 0 && notes[0].due <= cyc) begin
            n = notes.pop_front();
            compares++;
            if (seen(n.sel) !== n.exp) begin
                $display("[ERR] %s exp %h got %h", lbl[n.sel], n.exp, seen(n.sel));
                mismatches++;
            end
        end
    end
    // Hang guard
    initial begin
        repeat (5000) @(posedge ref_clk);
        $display("[ERR] run exp done got hung");
        mismatches++;
        tally_and_finish();
    end
    initial begin
        seed = 32'h644a;
        cyc = 0;
        nrst = 1'b0;
        knob_press = 1'b0;
        switch_up = 8'h00;
        led_on = 8'h00;
        button_pressed = 4'h0;
        pattern0 = 7'h00;
        pattern1 = 7'h00;
        knob_setting = 16'h0000;
        ext_drive = 32'h0;
        ext_oe_n = 32'hFFFFFFFF;
        line_out = 32'h0;
        line_is_output = 32'h0;
        repeat (3) @(posedge ref_clk);
        nrst <= 1'b1;
        note(4, 5, 32'h4);
        // Random LEDs, buttons, line directions and drive on both ends
        for (i = 0; i < 8; i++) begin
            @(posedge ref_clk);
            a = $random(seed);
            b = $random(seed);
            c = $random(seed);
            d = $random(seed);
            e = $random(seed);
            led_on <= a[7:0];
            button_pressed <= b[3:0];
            line_out <= a;
            line_is_output <= b;
            ext_drive <= c;
            ext_oe_n <= d;
            pattern0 <= e[6:0];
            pattern1 <= e[14:8];
            knob_setting <= e[31:16];
            note(6, 2, a & 32'hFF);
            note(6, 1, b & 32'hF);
            note(6, 3, (b & a) | (~b & ~d & c));
            note(6, 4, (b & a) | (~b & ~d & c));
            note(6, 7, 32'h1);
            repeat (7) @(posedge ref_clk);
        end
        // Settled switch, then short bounces that must be ignored
        @(posedge ref_clk);
        switch_up <= 8'hA5;
        note(14, 0, 32'hA5);
        repeat (16) @(posedge ref_clk);
        for (i = 0; i < 6; i++) begin
            switch_up <= i[0] ? 8'hA5 : 8'h5A;
            note(2, 0, 32'hA5);
            repeat (3) @(posedge ref_clk);
        end
        switch_up <= 8'h5A;
        note(14, 0, 32'h5A);
        repeat (16) @(posedge ref_clk);
        // Knob presses walk the ranges round, ending in the high range at full setting
        knob_setting <= 16'hFFFF;
        for (i = 0; i < 5; i++) begin
            knob_press <= 1'b1;
            note(6, 5, 32'h4 >> ((i + 1) % 3));
            repeat (3) @(posedge ref_clk);
            knob_press <= 1'b0;
            repeat (6) @(posedge ref_clk);
        end
        // Knob clock toggles once per half period near the top of the high range
        repeat (20) @(posedge ref_clk);
        knob_edges = 0;
        knob_last = knob_clk;
        for (i = 0; i < 240; i++) begin
            @(posedge ref_clk);
            if (knob_clk !== knob_last) knob_edges++;
            knob_last = knob_clk;
        end
        note(0, 6, 32'(240 / ((CLK_HZ / 2) / HIGH_MAX_HZ)));
        for (i = 0; i < 100 && notes.size() > 0; i++) @(posedge ref_clk);
        if (notes.size() > 0) mismatches++;
        tally_and_finish();
    end
endmodule : testbench
